//--- hw/scwr_pkg.sv
// package: constants for the supply control write register map
`default_nettype none
// Contract
// - voltage setpoint pair, 1.0 is nominal voltage
// - current setpoint pair, 1.0 is module current
// - third pair is power or process setpoint
// - peak output pair sets overvoltage threshold
// - impedance upper and lower limits, 24 fraction bits
// - impedance rise and fall rate limits
// - masked active fault shuts unit down
// - cable impedance and voltage drop maxima
// - impedance monitoring needs minimum output current
// - impedance and monitor filter coefficients held
// - defaults codes: store, restore saved, restore factory
// - query write starts query, result readable
// - nonzero expected count mismatch raises fault
// - setpoints slew limited per millisecond; float mode applies them at once
// - large setpoint step invalidates impedance; checked in fixed mode only
// - revalidate after delay in 8 ms units
// - inactivity timeout counted in 8 ms units
// - all ones locks, serial key unlocks
// - full-scale change rescales analog ports
// - clock time BCD in high, middle, low
// - five compensator coefficients B2 B1 B0 A2 A1
// - 32-bit value: high half first, MSBs
// - fixed point is value times two power
// - command bit selects fixed or float
// - process config: source, output, limit enable
package scwr_pkg;
	localparam int CLK_NS = 40;
	localparam int MS_NS = 1000000;
	localparam int MS_CYC = MS_NS / CLK_NS;
	localparam int UNIT_MS = 8;
	localparam int UNIT_CYC = UNIT_MS * MS_CYC;
	localparam int ADDR_W = 9;
	localparam int IDX_W = ADDR_W - 2;
	localparam int NPAIR = 25;
	localparam logic [6:0] PAIR_IDX [NPAIR] = '{
		7'h01, 7'h03, 7'h05, 7'h07, 7'h09, 7'h0B, 7'h0D, 7'h0F, 7'h11,
		7'h13, 7'h15, 7'h17, 7'h19, 7'h1F, 7'h21, 7'h23, 7'h25, 7'h29,
		7'h2B, 7'h2D, 7'h33, 7'h35, 7'h37, 7'h39, 7'h3B};
	localparam int P_VSET = 0;
	localparam int P_ISET = 1;
	localparam int P_PSET = 2;
	localparam int P_OVP = 3;
	localparam int P_SHUT = 8;
	localparam int P_IMIN = 11;
	localparam int P_VSLEW = 13;
	localparam int P_ISLEW = 14;
	localparam int P_STEP = 16;
	localparam int P_UNLOCK = 17;
	localparam int P_VFS = 18;
	localparam int P_IFS = 19;
	localparam logic [6:0] IDX_CMD = 7'h00;
	localparam logic [6:0] IDX_DEFAULTS = 7'h1B;
	localparam logic [6:0] IDX_QUERY = 7'h1C;
	localparam logic [6:0] IDX_EXPECT = 7'h1D;
	localparam logic [6:0] IDX_RECORDER = 7'h1E;
	localparam logic [6:0] IDX_ZDELAY = 7'h27;
	localparam logic [6:0] IDX_INACT = 7'h28;
	localparam logic [6:0] IDX_CLOCK_TIME_HIGH = 7'h2F;
	localparam logic [6:0] IDX_CLOCK_TIME_MIDDLE = 7'h30;
	localparam logic [6:0] IDX_CLOCK_TIME_LOW = 7'h31;
	localparam logic [6:0] IDX_PROC = 7'h32;
	localparam logic [6:0] IDX_LAST = 7'h3C;
	localparam logic [6:0] IDX_QINFO_HI = 7'h1D;
	localparam logic [6:0] IDX_QINFO_LO = 7'h1E;
	localparam logic [6:0] IDX_STATUS = 7'h40;
	localparam int CMD_RESET_FAULT = 1;
	localparam int CMD_ZMON = 4;
	localparam int CMD_TIMEOUT = 5;
	localparam int CMD_FLOAT = 6;
	localparam int PROC_SRC = 0;
	localparam int PROC_OUT = 1;
	localparam int PROC_LIM = 2;
	localparam logic [15:0] DEF_STORE = 16'h1234;
	localparam logic [15:0] DEF_RESTORE = 16'h5678;
	localparam logic [15:0] DEF_FACTORY = 16'h9ABC;
	localparam logic [31:0] LOCK_CODE = 32'hFFFFFFFF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	localparam int ST_W = 6;
endpackage
`default_nettype wire

//--- hw/scwr_tick.sv
// periodic one-cycle tick generator
`default_nettype none
module scwr_tick #(
	parameter int DIV = 25000
) (
	input wire logic core_clk,
	input wire logic rst_n,
	output logic tick
);
	import scwr_pkg::*;
	if (DIV < 1) begin : g_bad
		$error("scwr_tick: DIV below one");
	end
	logic [31:0] cnt_reg, cnt_next;
	logic tick_reg, tick_next;
	always_comb begin
		tick_next = 1'b0;
		cnt_next = cnt_reg + 32'h00000001;
		if (cnt_reg >= 32'(DIV - 1)) begin
			cnt_next = 32'h00000000;
			tick_next = 1'b1;
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cnt_reg <= 32'h00000000;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end
	assign tick = tick_reg;
endmodule
`default_nettype wire

//--- hw/scwr_half_pair.sv
// one 32-bit value written as two 16-bit halves
`default_nettype none
module scwr_half_pair (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic wr_hi,
	input wire logic wr_lo,
	input wire logic [15:0] wdata,
	output logic [31:0] value,
	output logic commit
);
	logic [15:0] hi_reg, hi_next, lo_reg, lo_next;
	logic hs_reg, hs_next, ls_reg, ls_next, cm_reg, cm_next;
	logic [31:0] val_reg, val_next;
	always_comb begin
		hi_next = hi_reg;
		lo_next = lo_reg;
		hs_next = hs_reg;
		ls_next = ls_reg;
		val_next = val_reg;
		cm_next = 1'b0;
		// halves may come in either order; the second one applies
		if (wr_hi) begin
			if (ls_reg) begin
				val_next = {wdata, lo_reg};
				cm_next = 1'b1;
				ls_next = 1'b0;
			end else begin
				hi_next = wdata;
				hs_next = 1'b1;
			end
		end
		if (wr_lo) begin
			if (hs_reg) begin
				val_next = {hi_reg, wdata};
				cm_next = 1'b1;
				hs_next = 1'b0;
			end else begin
				lo_next = wdata;
				ls_next = 1'b1;
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			hi_reg <= 16'h0000;
			lo_reg <= 16'h0000;
			hs_reg <= 1'b0;
			ls_reg <= 1'b0;
			val_reg <= 32'h00000000;
			cm_reg <= 1'b0;
		end else begin
			hi_reg <= hi_next;
			lo_reg <= lo_next;
			hs_reg <= hs_next;
			ls_reg <= ls_next;
			val_reg <= val_next;
			cm_reg <= cm_next;
		end
	end
	assign value = val_reg;
	assign commit = cm_reg;
	a_half_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		(wr_hi && !wr_lo && !ls_reg) |=> $stable(value))
		else $error("value changed on a lone half");
	a_pair_join: assert property (@(posedge core_clk) disable iff (!rst_n)
		(wr_lo && !wr_hi && hs_reg) |=> (value == {$past(hi_reg), $past(wdata)}) && commit)
		else $error("pair not joined high over low");
endmodule
`default_nettype wire

//--- hw/scwr_regs.sv
// write register map of the supply master controller, AXI4-Lite slave
`default_nettype none
module scwr_regs #(
	parameter int MS_CYCLES = scwr_pkg::MS_CYC,
	parameter int UNIT_CYCLES = scwr_pkg::UNIT_CYC
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [scwr_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [scwr_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] fault_bits,
	input wire logic [15:0] discovered_modules,
	input wire logic [31:0] current_feedback,
	input wire logic [31:0] unlock_key,
	input wire logic query_done,
	input wire logic [31:0] query_data,
	output logic [scwr_pkg::NPAIR-1:0][31:0] pair_value,
	output logic [15:0] unit_command_word,
	output logic float_encoding_select,
	output logic [31:0] voltage_applied,
	output logic [31:0] current_applied,
	output logic shutdown_req,
	output logic module_count_fault,
	output logic impedance_valid,
	output logic impedance_monitor_active,
	output logic link_timeout,
	output logic iface_locked,
	output logic defaults_store,
	output logic defaults_restore,
	output logic defaults_factory,
	output logic query_start,
	output logic [15:0] query_word,
	output logic rescale_pulse,
	output logic rtc_load,
	output logic [47:0] rtc_bcd,
	output logic [15:0] recorder_period_config,
	output logic process_setpoint_digital,
	output logic process_output_voltage,
	output logic process_limit_active
);
	import scwr_pkg::*;
	if (MS_CYCLES < 1 || UNIT_CYCLES < MS_CYCLES) begin : g_bad
		$error("scwr_regs: tick counts out of range");
	end

	function automatic logic [31:0] absdiff(input logic [31:0] a, input logic [31:0] b);
		absdiff = (a > b) ? a - b : b - a;
	endfunction

	function automatic logic [31:0] slew_to(input logic [31:0] cur, input logic [31:0] tgt,
			input logic [31:0] lim);
		// a zero limit means unlimited
		if (lim == 32'h00000000 || absdiff(cur, tgt) <= lim) begin
			slew_to = tgt;
		end else if (tgt > cur) begin
			slew_to = cur + lim;
		end else begin
			slew_to = cur - lim;
		end
	endfunction

	logic ms_tick, unit_tick;
	scwr_tick #(.DIV(MS_CYCLES)) u_ms (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.tick(ms_tick)
	);
	scwr_tick #(.DIV(UNIT_CYCLES)) u_unit (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.tick(unit_tick)
	);

	// write channel
	logic awg_reg, awg_next, wg_reg, wg_next, bv_reg, bv_next;
	logic [ADDR_W-1:0] awa_reg, awa_next;
	logic [31:0] wd_reg, wd_next;
	logic [3:0] ws_reg, ws_next;
	logic [1:0] br_reg, br_next, wr_resp;
	logic [IDX_W-1:0] widx;
	logic wr_go, wr_en, unlock_idx, lock_reg, lock_next;
	logic [15:0] wlo;

	assign s_axi_awready = !awg_reg && !bv_reg;
	assign s_axi_wready = !wg_reg && !bv_reg;
	assign wr_go = awg_reg && wg_reg && !bv_reg;
	assign widx = awa_reg[ADDR_W-1:2];
	assign wlo = wd_reg[15:0];
	assign unlock_idx = widx == PAIR_IDX[P_UNLOCK] || widx == PAIR_IDX[P_UNLOCK] + 7'h01;
	assign wr_en = wr_go && wr_resp == RESP_OKAY;

	always_comb begin
		if (widx > IDX_LAST) begin
			wr_resp = RESP_DECERR;
		end else if (lock_reg && !unlock_idx) begin
			wr_resp = RESP_SLVERR;
		end else if (ws_reg[1:0] != 2'h3) begin
			wr_resp = RESP_SLVERR;
		end else begin
			wr_resp = RESP_OKAY;
		end
	end

	always_comb begin
		awg_next = awg_reg;
		wg_next = wg_reg;
		awa_next = awa_reg;
		wd_next = wd_reg;
		ws_next = ws_reg;
		bv_next = bv_reg;
		br_next = br_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			awg_next = 1'b1;
			awa_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wg_next = 1'b1;
			wd_next = s_axi_wdata;
			ws_next = s_axi_wstrb;
		end
		if (bv_reg && s_axi_bready) begin
			bv_next = 1'b0;
		end
		if (wr_go) begin
			awg_next = 1'b0;
			wg_next = 1'b0;
			bv_next = 1'b1;
			br_next = wr_resp;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			awg_reg <= 1'b0;
			wg_reg <= 1'b0;
			awa_reg <= '0;
			wd_reg <= 32'h00000000;
			ws_reg <= 4'h0;
			bv_reg <= 1'b0;
			br_reg <= RESP_OKAY;
		end else begin
			awg_reg <= awg_next;
			wg_reg <= wg_next;
			awa_reg <= awa_next;
			wd_reg <= wd_next;
			ws_reg <= ws_next;
			bv_reg <= bv_next;
			br_reg <= br_next;
		end
	end
	assign s_axi_bvalid = bv_reg;
	assign s_axi_bresp = br_reg;

	// 32-bit pairs; values stay raw, fixed or float as software chose
	logic [NPAIR-1:0] pcommit;
	for (genvar k = 0; k < NPAIR; k++) begin : g_pair
		scwr_half_pair u_pair (
			.core_clk(core_clk),
			.rst_n(rst_n),
			.wr_hi(wr_en && widx == PAIR_IDX[k]),
			.wr_lo(wr_en && widx == 7'(PAIR_IDX[k] + 7'h01)),
			.wdata(wlo),
			.value(pair_value[k]),
			.commit(pcommit[k])
		);
	end

	// single registers and event pulses
	logic [15:0] cmd_reg, cmd_next, exp_reg, exp_next, rec_reg, rec_next;
	logic [15:0] zdl_reg, zdl_next, ina_reg, ina_next, proc_reg, proc_next;
	logic [15:0] qw_reg, qw_next, thi_reg, thi_next, tmd_reg, tmd_next;
	logic [47:0] rtc_reg, rtc_next;
	logic [31:0] qd_reg, qd_next;
	logic dst_reg, dst_next, drs_reg, drs_next;
	logic dfa_reg, dfa_next, qs_reg, qs_next, rtl_reg, rtl_next, rsc_reg, rsc_next;

	always_comb begin
		cmd_next = cmd_reg;
		exp_next = exp_reg;
		rec_next = rec_reg;
		zdl_next = zdl_reg;
		ina_next = ina_reg;
		proc_next = proc_reg;
		qw_next = qw_reg;
		thi_next = thi_reg;
		tmd_next = tmd_reg;
		rtc_next = rtc_reg;
		qd_next = qd_reg;
		lock_next = lock_reg;
		dst_next = 1'b0;
		drs_next = 1'b0;
		dfa_next = 1'b0;
		qs_next = 1'b0;
		rtl_next = 1'b0;
		rsc_next = pcommit[P_VFS] || pcommit[P_IFS];
		if (query_done) begin
			qd_next = query_data;
		end
		if (pcommit[P_UNLOCK]) begin
			if (pair_value[P_UNLOCK] == LOCK_CODE) begin
				lock_next = 1'b1;
			end else if (pair_value[P_UNLOCK] == unlock_key) begin
				lock_next = 1'b0;
			end
		end
		if (wr_en) begin
			case (widx)
				IDX_CMD: cmd_next = wlo;
				IDX_DEFAULTS: begin
					// any other code is dropped silently
					dst_next = wlo == DEF_STORE;
					drs_next = wlo == DEF_RESTORE;
					dfa_next = wlo == DEF_FACTORY;
				end
				IDX_QUERY: begin
					qw_next = wlo;
					qs_next = 1'b1;
				end
				IDX_EXPECT: exp_next = wlo;
				IDX_RECORDER: rec_next = wlo;
				IDX_ZDELAY: zdl_next = wlo;
				IDX_INACT: ina_next = wlo;
				IDX_CLOCK_TIME_HIGH: thi_next = wlo;
				IDX_CLOCK_TIME_MIDDLE: tmd_next = wlo;
				IDX_CLOCK_TIME_LOW: begin
					rtc_next = {thi_reg, tmd_reg, wlo};
					rtl_next = 1'b1;
				end
				IDX_PROC: proc_next = wlo;
				default: cmd_next = cmd_reg;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cmd_reg <= 16'h0000;
			exp_reg <= 16'h0000;
			rec_reg <= 16'h0000;
			zdl_reg <= 16'h0000;
			ina_reg <= 16'h0000;
			proc_reg <= 16'h0000;
			qw_reg <= 16'h0000;
			thi_reg <= 16'h0000;
			tmd_reg <= 16'h0000;
			rtc_reg <= 48'h000000000000;
			qd_reg <= 32'h00000000;
			lock_reg <= 1'b0;
			dst_reg <= 1'b0;
			drs_reg <= 1'b0;
			dfa_reg <= 1'b0;
			qs_reg <= 1'b0;
			rtl_reg <= 1'b0;
			rsc_reg <= 1'b0;
		end else begin
			cmd_reg <= cmd_next;
			exp_reg <= exp_next;
			rec_reg <= rec_next;
			zdl_reg <= zdl_next;
			ina_reg <= ina_next;
			proc_reg <= proc_next;
			qw_reg <= qw_next;
			thi_reg <= thi_next;
			tmd_reg <= tmd_next;
			rtc_reg <= rtc_next;
			qd_reg <= qd_next;
			lock_reg <= lock_next;
			dst_reg <= dst_next;
			drs_reg <= drs_next;
			dfa_reg <= dfa_next;
			qs_reg <= qs_next;
			rtl_reg <= rtl_next;
			rsc_reg <= rsc_next;
		end
	end

	// protection, slew and impedance supervision
	logic [31:0] va_reg, va_next, ia_reg, ia_next, vo_reg, io_reg;
	logic [15:0] zc_reg, zc_next, idle_reg, idle_next;
	logic sd_reg, sd_next, mf_reg, mf_next, zv_reg, zv_next;
	logic zm_reg, zm_next, to_reg, to_next, step, fsel;

	assign fsel = cmd_reg[CMD_FLOAT];
	// float steps cannot be measured in integer logic, so only fixed mode checks
	assign step = !fsel && (absdiff(pair_value[P_VSET], vo_reg) > pair_value[P_STEP]
		|| absdiff(pair_value[P_ISET], io_reg) > pair_value[P_STEP]);

	always_comb begin
		va_next = va_reg;
		ia_next = ia_reg;
		zc_next = zc_reg;
		zv_next = zv_reg;
		idle_next = idle_reg;
		sd_next = sd_reg;
		if (fsel) begin
			va_next = pair_value[P_VSET];
			ia_next = pair_value[P_ISET];
		end else if (ms_tick) begin
			va_next = slew_to(va_reg, pair_value[P_VSET], pair_value[P_VSLEW]);
			ia_next = slew_to(ia_reg, pair_value[P_ISET], pair_value[P_ISLEW]);
		end
		if (step) begin
			zv_next = 1'b0;
			zc_next = zdl_reg;
		end else if (zc_reg != 16'h0000) begin
			if (unit_tick) begin
				zc_next = zc_reg - 16'h0001;
			end
		end else begin
			zv_next = 1'b1;
		end
		zm_next = cmd_reg[CMD_ZMON] && zv_reg
			&& current_feedback >= pair_value[P_IMIN];
		mf_next = exp_reg != 16'h0000 && discovered_modules != exp_reg;
		if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
			idle_next = 16'h0000;
		end else if (unit_tick && idle_reg != 16'hFFFF) begin
			idle_next = idle_reg + 16'h0001;
		end
		to_next = cmd_reg[CMD_TIMEOUT] && ina_reg != 16'h0000 && idle_reg >= ina_reg;
		// a new fault outranks a reset request in the same cycle
		if (wr_en && widx == IDX_CMD && wlo[CMD_RESET_FAULT]) begin
			sd_next = 1'b0;
		end
		if ((fault_bits & pair_value[P_SHUT]) != 32'h00000000) begin
			sd_next = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			va_reg <= 32'h00000000;
			ia_reg <= 32'h00000000;
			vo_reg <= 32'h00000000;
			io_reg <= 32'h00000000;
			zc_reg <= 16'h0000;
			idle_reg <= 16'h0000;
			sd_reg <= 1'b0;
			mf_reg <= 1'b0;
			zv_reg <= 1'b0;
			zm_reg <= 1'b0;
			to_reg <= 1'b0;
		end else begin
			va_reg <= va_next;
			ia_reg <= ia_next;
			vo_reg <= pair_value[P_VSET];
			io_reg <= pair_value[P_ISET];
			zc_reg <= zc_next;
			idle_reg <= idle_next;
			sd_reg <= sd_next;
			mf_reg <= mf_next;
			zv_reg <= zv_next;
			zm_reg <= zm_next;
			to_reg <= to_next;
		end
	end

	// read channel: query result and block status
	logic rv_reg, rv_next;
	logic [31:0] rd_reg, rd_next;
	logic [1:0] rr_reg, rr_next;
	logic [IDX_W-1:0] ridx;
	assign ridx = s_axi_araddr[ADDR_W-1:2];
	assign s_axi_arready = !rv_reg;

	always_comb begin
		rv_next = rv_reg;
		rd_next = rd_reg;
		rr_next = rr_reg;
		if (rv_reg && s_axi_rready) begin
			rv_next = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rv_next = 1'b1;
			rr_next = RESP_OKAY;
			rd_next = 32'h00000000;
			case (ridx)
				IDX_QINFO_HI: rd_next = {16'h0000, qd_reg[31:16]};
				IDX_QINFO_LO: rd_next = {16'h0000, qd_reg[15:0]};
				IDX_STATUS: rd_next = {26'h0000000, zm_reg, to_reg, mf_reg, sd_reg, zv_reg,
					lock_reg};
				default: rr_next = (ridx > IDX_LAST) ? RESP_DECERR : RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rv_reg <= 1'b0;
			rd_reg <= 32'h00000000;
			rr_reg <= RESP_OKAY;
		end else begin
			rv_reg <= rv_next;
			rd_reg <= rd_next;
			rr_reg <= rr_next;
		end
	end
	assign s_axi_rvalid = rv_reg;
	assign s_axi_rdata = rd_reg;
	assign s_axi_rresp = rr_reg;

	assign unit_command_word = cmd_reg;
	assign float_encoding_select = fsel;
	assign voltage_applied = va_reg;
	assign current_applied = ia_reg;
	assign shutdown_req = sd_reg;
	assign module_count_fault = mf_reg;
	assign impedance_valid = zv_reg;
	assign impedance_monitor_active = zm_reg;
	assign link_timeout = to_reg;
	assign iface_locked = lock_reg;
	assign defaults_store = dst_reg;
	assign defaults_restore = drs_reg;
	assign defaults_factory = dfa_reg;
	assign query_start = qs_reg;
	assign query_word = qw_reg;
	assign rescale_pulse = rsc_reg;
	assign rtc_load = rtl_reg;
	assign rtc_bcd = rtc_reg;
	assign recorder_period_config = rec_reg;
	assign process_setpoint_digital = proc_reg[PROC_SRC];
	assign process_output_voltage = proc_reg[PROC_OUT];
	assign process_limit_active = proc_reg[PROC_LIM];

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_fault_shuts_unit: assert property (
		((fault_bits & pair_value[P_SHUT]) != 32'h00000000) |=> shutdown_req ##1 shutdown_req)
		else $error("masked fault did not hold shutdown");
	a_count_mismatch: assert property (
		(exp_reg != 16'h0000 && discovered_modules != exp_reg) |=> module_count_fault)
		else $error("module count mismatch not flagged");
	a_lock_on_ones: assert property (
		(pcommit[P_UNLOCK] && pair_value[P_UNLOCK] == LOCK_CODE) |=> iface_locked)
		else $error("all ones did not lock");
	a_locked_cmd_kept: assert property (
		(lock_reg && wr_go && widx == IDX_CMD) |=> $stable(cmd_reg) && s_axi_bresp == RESP_SLVERR)
		else $error("locked write changed command");
	a_odd_code_quiet: assert property (
		(wr_en && widx == IDX_DEFAULTS && wlo != DEF_STORE && wlo != DEF_RESTORE
			&& wlo != DEF_FACTORY) |=> !(defaults_store || defaults_restore || defaults_factory))
		else $error("unknown defaults code acted");
	a_store_pulse: assert property (
		(wr_en && widx == IDX_DEFAULTS && wlo == DEF_STORE) |=> defaults_store ##1 !defaults_store)
		else $error("store pulse wrong");
	a_step_invalid: assert property (
		step |=> !impedance_valid)
		else $error("step left impedance valid");
	// with a zero delay the flag may come back on the second cycle
	a_delay_hold: assert property (
		(step && zdl_reg != 16'h0000) |=> !impedance_valid [*2])
		else $error("impedance revalidated before delay");
	a_zmon_gate: assert property (
		impedance_monitor_active |-> $past(current_feedback) >= $past(pair_value[P_IMIN]))
		else $error("monitor active below minimum current");
	a_slew_bound: assert property (
		(!fsel && !$past(fsel) && $stable(pair_value[P_VSLEW]) && pair_value[P_VSLEW] != 0)
		|-> absdiff(va_reg, $past(va_reg)) <= pair_value[P_VSLEW])
		else $error("voltage moved faster than slew limit");
	a_query_starts: assert property (
		(wr_en && widx == IDX_QUERY) |=> query_start && query_word == $past(wlo))
		else $error("query write did not start query");
endmodule
`default_nettype wire

//--- verif/scwr_host.sv
// host-side AXI4-Lite master model that writes and reads the register map
`default_nettype none
module scwr_host (
	input wire logic core_clk,
	output logic [scwr_pkg::ADDR_W-1:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [scwr_pkg::ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ns;
	import scwr_pkg::*;
	// ready lines stay high, so no answer is ever missed
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		{s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3F;
	end
	// handshakes sampled at the falling edge, acted on at the next rising edge
	task automatic wr(input logic [6:0] i, input logic [15:0] v, output logic [1:0] r);
		logic a, w, ta, tw, t;
		a = 0;
		w = 0;
		t = 0;
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= {16'h0, v};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		while (!(a && w)) begin
			@(negedge core_clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			@(posedge core_clk);
			a = a | ta;
			w = w | tw;
			s_axi_awvalid <= !a;
			s_axi_wvalid <= !w;
		end
		while (!t) begin
			@(negedge core_clk);
			t = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge core_clk);
		end
	endtask
	task automatic rd(input logic [6:0] i, output logic [31:0] d, output logic [1:0] r);
		logic t;
		t = 0;
		s_axi_araddr <= {i, 2'h0};
		s_axi_arvalid <= 1;
		while (!t) begin
			@(negedge core_clk);
			t = s_axi_arready;
			@(posedge core_clk);
		end
		s_axi_arvalid <= 0;
		t = 0;
		while (!t) begin
			@(negedge core_clk);
			t = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge core_clk);
		end
	endtask
endmodule
`default_nettype wire

//--- verif/tb.sv
// self-checking bench for the supply control write register map
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import scwr_pkg::*;
	logic core_clk = 0;
	logic rst_n = 0;
	logic query_done = 0;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, fault_bits = 0, unlock_key = 0, query_data = 0;
	logic [3:0] s_axi_wstrb, n_st = 0, n_rs = 0, n_fa = 0, n_q = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [15:0] discovered_modules = 0;
	logic [NPAIR-1:0][31:0] pair_value;
	logic shutdown_req, module_count_fault, iface_locked, impedance_monitor_active;
	logic [15:0] query_word;
	logic [47:0] rtc_bcd;
	logic defaults_store, defaults_restore, defaults_factory, query_start;
	logic [15:0] c [4] = '{DEF_STORE, DEF_RESTORE, DEF_FACTORY, 16'h1235};
	int n_errors = 0;
	int checks = 0;
	always #20 core_clk = ~core_clk;
	// skip reset edges, where the pulses are still unknown
	always @(posedge core_clk) begin
		if (rst_n) begin
			n_st <= n_st + 4'(defaults_store);
			n_rs <= n_rs + 4'(defaults_restore);
			n_fa <= n_fa + 4'(defaults_factory);
			n_q <= n_q + 4'(query_start);
		end
	end
	scwr_host host (.core_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	// short tick counts keep the run brief
	scwr_regs #(.MS_CYCLES(4), .UNIT_CYCLES(32)) uut (.core_clk, .rst_n, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .fault_bits, .discovered_modules, .current_feedback(32'h0), .unlock_key,
		.query_done, .query_data, .pair_value, .unit_command_word(), .float_encoding_select(),
		.voltage_applied(), .current_applied(), .shutdown_req, .module_count_fault,
		.impedance_valid(), .impedance_monitor_active, .link_timeout(), .iface_locked,
		.defaults_store, .defaults_restore, .defaults_factory, .query_start, .query_word,
		.rescale_pulse(), .rtc_load(), .rtc_bcd, .recorder_period_config(),
		.process_setpoint_digital(), .process_output_voltage(), .process_limit_active());
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task w(input logic [6:0] i, input logic [15:0] v);
		host.wr(i, v, r);
	endtask
	task step(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	initial begin
		step(8);
		rst_n <= 1;
		step(1);
		w(IDX_ZDELAY, 16'h0001);
		w(7'h01, 16'hA5C3);
		chk("bresp", 32'(r), 32'(RESP_OKAY));
		chk("vset half", pair_value[P_VSET], 32'h0);
		w(7'h02, 16'h0F1E);
		step(1);
		chk("vset", pair_value[P_VSET], 32'hA5C30F1E);
		w(7'h04, 16'h0001);
		w(7'h03, 16'h8000);
		step(1);
		chk("iset", pair_value[P_ISET], 32'h80000001);
		$display("test pairs done");
		foreach (c[k]) w(IDX_DEFAULTS, c[k]);
		step(2);
		chk("store", 32'(n_st), 32'h1);
		chk("restore", 32'(n_rs), 32'h1);
		chk("factory", 32'(n_fa), 32'h1);
		chk("odd code", 32'(n_st + n_rs + n_fa), 32'h3);
		$display("test defaults done");
		fault_bits <= 32'h1;
		w(7'h11, 16'h0000);
		w(7'h12, 16'h0008);
		step(3);
		chk("shut unmasked", 32'(shutdown_req), 32'h0);
		fault_bits <= 32'h8;
		step(3);
		chk("shut masked", 32'(shutdown_req), 32'h1);
		discovered_modules <= 16'h2;
		w(IDX_EXPECT, 16'h0003);
		step(3);
		chk("count bad", 32'(module_count_fault), 32'h1);
		discovered_modules <= 16'h3;
		step(3);
		chk("count ok", 32'(module_count_fault), 32'h0);
		$display("test faults done");
		w(IDX_QUERY, 16'h0502);
		step(1);
		chk("query start", 32'(n_q), 32'h1);
		chk("query word", 32'(query_word), 32'h0502);
		query_data <= 32'hCAFE0001;
		query_done <= 1;
		step(1);
		query_done <= 0;
		host.rd(7'h1D, d, r);
		chk("query hi", d, 32'h0000CAFE);
		host.rd(7'h1E, d, r);
		chk("query lo", d, 32'h00000001);
		$display("test query done");
		w(7'h29, 16'hFFFF);
		w(7'h2A, 16'hFFFF);
		step(2);
		chk("locked", 32'(iface_locked), 32'h1);
		w(7'h01, 16'h1111);
		chk("locked write", 32'(r), 32'(RESP_SLVERR));
		unlock_key <= 32'h13579BDF;
		w(7'h29, 16'h1357);
		w(7'h2A, 16'h9BDF);
		step(2);
		chk("unlocked", 32'(iface_locked), 32'h0);
		w(IDX_CMD, 16'h0010);
		step(2);
		chk("zmon", 32'(impedance_monitor_active), 32'h1);
		w(IDX_CLOCK_TIME_HIGH, 16'h0012);
		w(IDX_CLOCK_TIME_MIDDLE, 16'h3456);
		w(IDX_CLOCK_TIME_LOW, 16'h7890);
		step(1);
		chk("rtc hi", 32'(rtc_bcd[47:32]), 32'h00000012);
		chk("rtc lo", rtc_bcd[31:0], 32'h34567890);
		w(7'h3D, 16'h0000);
		chk("unmapped write", 32'(r), 32'(RESP_DECERR));
		host.rd(7'h3D, d, r);
		chk("unmapped read", 32'(r), 32'(RESP_DECERR));
		$display("test lock done");
		final_report;
	end
	// far beyond the hundred or so cycles the tests need
	initial begin
		#800000;
		n_errors++;
		final_report;
	end
endmodule
`default_nettype wire
